// *** fpl_params.svh ***
// Constants of the flash program and lock controller: offsets, codes, timing.
// Included by the package, the flash array and the top file; definitions only.
`ifndef FPL_PARAMS_SVH
`define FPL_PARAMS_SVH
`define FPL_ADDR_W 14
`define FPL_ADDR_LAST 14'h2FFF
`define FPL_ERASED 8'hFF
`define FPL_ERASE_READ 8'h00
`define FPL_SIG0_ADDR 14'h0030
`define FPL_SIG1_ADDR 14'h0031
`define FPL_LOCK_ADDR 14'h0032
`define FPL_MODE_ERASE 4'h8
`define FPL_MODE_WRITE 4'h7
`define FPL_MODE_READ 4'h3
`define FPL_MODE_LOCK 4'hA
`define FPL_MODE_SIG 4'h0
`define FPL_SER_PREFIX 8'hAC
`define FPL_SER_ENABLE 8'h53
`define FPL_SER_ERASE 3'h4
`define FPL_SER_LOCK 3'h7
`define FPL_SER_RD 2'h1
`define FPL_SER_WR 2'h2
`define FPL_CLK_MHZ 125
`define FPL_T_WRITE_US 1500
`define FPL_T_SERASE_US 16000
`define FPL_TMR_W 21
`define FPL_REG_STATUS 12'h000
`define FPL_REG_CTRL 12'h004
`define FPL_REG_LAST 12'h008
`define FPL_CTRL_RESET 1'h1
`endif

// *** fpl_pkg.sv ***
// Types shared by the flash program and lock controller files.
// Assumes fpl_params.svh is on the include path.
`include "fpl_params.svh"
package fpl_pkg;
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PWRITE = 6'h02,
    ST_SWRITE = 6'h04,
    ST_LOCKW = 6'h08,
    ST_SERASE = 6'h10,
    ST_PERASE = 6'h20
  } fpl_state_t;
  // Parallel programming pins grouped: mode select, address, write data
  typedef struct packed {
    logic [3:0] mode;
    logic [`FPL_ADDR_W-1:0] addr;
    logic [7:0] data;
  } fpl_par_req_t;
endpackage : fpl_pkg

// *** fpl_flash_array.sv ***
// Code flash array: 12K bytes, synchronous read, byte write, erase sweep.
// Assumes one write or one erase at a time, ordered by the sequencer.
`timescale 1ns/1ps
`include "fpl_params.svh"
module fpl_flash_array (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [`FPL_ADDR_W-1:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic i_wr_and,
  input wire logic [`FPL_ADDR_W-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_erase_start,
  output logic o_erase_busy
);
  logic [7:0] mem [0:`FPL_ADDR_LAST];
  logic [`FPL_ADDR_W-1:0] sweep_r;
  // Shipped erased: every byte starts at all ones
  initial begin
    for (int i = 0; i <= `FPL_ADDR_LAST; i++) begin
      mem[i] = `FPL_ERASED;
    end
  end
  // Erase sweeps one byte per cycle, 12288 cycles; far shorter than the default serial erase time
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_erase_busy <= 1'b0;
      sweep_r <= '0;
    end else if (i_erase_start) begin
      o_erase_busy <= 1'b1;
      sweep_r <= '0;
    end else if (o_erase_busy) begin
      sweep_r <= sweep_r + 14'h1;
      if (sweep_r == `FPL_ADDR_LAST) begin
        o_erase_busy <= 1'b0;
      end
    end
  end
  // Parallel writes only clear bits, so a non-blank byte needs an erase
  always_ff @(posedge i_clk_sys) begin
    o_rd_data <= mem[i_rd_addr];
    if (o_erase_busy) begin
      mem[sweep_r] <= `FPL_ERASED; // see [R17]
    end else if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_and ? (mem[i_wr_addr] & i_wr_data) : i_wr_data; // see [R4]
    end
  end
  a_erase_begins: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R17]
    i_erase_start |=> o_erase_busy)
    else $error("erase sweep did not begin");
endmodule : fpl_flash_array

// *** fpl_ser_shift.sv ***
// Serial programming shifter: byte in on rising clock, byte out on falling.
// Assumes the serial clock is synchronous and far slower than i_clk_sys.
`timescale 1ns/1ps
module fpl_ser_shift (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_active,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_tx_load,
  input wire logic [7:0] i_tx_byte,
  output logic o_miso,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid
);
  logic sck_r;
  logic [2:0] bit_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic sck_rise;
  logic sck_fall;
  assign sck_rise = i_sck & ~sck_r;
  assign sck_fall = ~i_sck & sck_r;
  assign o_miso = tx_r[7];
  // Receive: framing restarts whenever the interface is inactive
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sck_r <= 1'b0;
      bit_r <= 3'h0;
      rx_r <= 8'h00;
      o_rx_byte <= 8'h00;
      o_rx_valid <= 1'b0;
    end else begin
      sck_r <= i_sck;
      o_rx_valid <= 1'b0;
      if (!i_active) begin
        bit_r <= 3'h0;
      end else if (sck_rise) begin
        rx_r <= {rx_r[6:0], i_mosi};
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h7) begin
          o_rx_byte <= {rx_r[6:0], i_mosi};
          o_rx_valid <= 1'b1;
        end
      end
    end
  end
  // Transmit: a load puts the MSB out before the next rising edge
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_r <= 8'hFF;
    end else if (i_tx_load) begin
      tx_r <= i_tx_byte;
    end else if (sck_fall && i_active && bit_r != 3'h0) begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end
  a_rx_on_edge: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R24]
    o_rx_valid |-> $past(sck_rise) && $past(bit_r) == 3'h7)
    else $error("byte completed without eighth clock");
endmodule : fpl_ser_shift

// *** fpl_top.sv ***
// Flash program and lock controller: parallel and serial programming,
// chip erase, completion polling, ready/busy, lock bits, fuse, identity.
// Assumes pins synchronous to i_clk_sys; APB slave for status and control.
// Contract
// [R1] Code flash is one byte-addressed space from 0000H to 2FFFH.
// [R2] The array starts erased, every byte reading FFH.
// [R3] Serial byte write erases the byte itself, then stores new data.
// [R4] Parallel write has no auto erase; non-blank bytes need chip erase.
// [R5] Lock one: table reads blocked, access pin latched, programming refused.
// [R6] Lock one and two: also refuse verify reads in both modes.
// [R7] All three locks: also block execution from external memory.
// [R8] Lock one latches the access pin level while reset is held.
// [R9] Only a chip erase, either mode, clears programmed lock bits.
// [R10] Programmer drives mode pins, fourteen address bits and data.
// [R11] One strobe pulse per write; device times the write itself.
// [R12] Second mode pin low makes the device drive the stored byte.
// [R13] During a write, last byte reads back with its top bit inverted.
// [R14] True data returns when the write ends; polling may start anytime.
// [R15] Ready/busy goes low after strobe rises, high when write completes.
// [R16] Readback only without locks one and two; lock state readable parallel.
// [R17] Parallel erase: erase mode, strobe held low, array set to ones.
// [R18] Serial erase instruction starts a self-timed erase of about 16 ms.
// [R19] Serial reads during chip erase return 00H.
// [R20] A fuse disables serial programming; set only in parallel mode.
// [R21] Identity bytes read at 030H and 031H with mode pins three, four low.
// [R22] Programmer holds reset high, code strobe low, raises programming voltage.
// [R23] Mode codes: erase HLLL, write LHHH, read LLHH, lock HLHL.
// [R24] Serial instructions are three bytes; enable is AC, 53, don't care.
// [R25] Forbidden requests are ignored; array unchanged, ready/busy stays ready.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fpl_params.svh"
module fpl_top #(
  parameter int unsigned WRITE_CYC = `FPL_T_WRITE_US * `FPL_CLK_MHZ,
  parameter int unsigned SERASE_CYC = `FPL_T_SERASE_US * `FPL_CLK_MHZ,
  parameter logic [7:0] ID_MAKER = 8'h5A, // Arbitrary value
  parameter logic [7:0] ID_PART = 8'hC3 // Arbitrary value
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_dev_reset_pin,
  input wire logic i_code_store_strobe,
  input wire logic i_external_fetch_select,
  input wire logic i_external_fetch_program_voltage,
  input wire logic i_prog_strobe,
  input wire fpl_pkg::fpl_par_req_t i_par_req,
  output logic [7:0] o_pdata,
  output logic o_pdata_oe,
  output logic o_ready_busy_indicator,
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_code_table_read_block,
  output logic o_ext_exec_block,
  output logic o_ea_latched,
  output logic o_external_fetch_used
);
  import fpl_pkg::*;
  fpl_state_t st_r;
  logic [`FPL_TMR_W-1:0] tmr_r;
  logic [2:0] lock_r; // [0] lock_bit_one .. [2] lock_bit_three
  logic fuse_r;
  logic ea_latch_r;
  logic ctrl_en_r;
  logic strobe_r;
  logic [13:0] last_addr_r;
  logic [7:0] last_data_r;
  logic [2:0] lock_pend_r;
  logic fuse_pend_r;
  logic ser_en_r;
  logic [1:0] ser_idx_r;
  logic [7:0] b1_r;
  logic [7:0] b2_r;
  logic [1:0] rd_pend_r;
  logic [13:0] ser_addr_r;
  logic [7:0] rd_data;
  logic erase_busy;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] ser_tx;
  logic strobe_rise;
  logic strobe_fall;
  logic par_on;
  logic ser_on;
  logic mode_rd;
  logic mode_sig;
  logic wr_done;
  logic erase_start;
  logic ser_go;
  logic ser_wr;
  logic ser_lock;
  logic ser_erase;
  logic erasing;
  logic apb_acc;
  logic [31:0] rd_mux;
  logic mapped;

  // Programming entry: reset pin high, code strobe low, voltage raised
  assign par_on = i_dev_reset_pin & ~i_code_store_strobe
                & i_external_fetch_program_voltage & ctrl_en_r; // see [R22]
  // Serial path only when not in parallel mode and the fuse is intact
  assign ser_on = i_dev_reset_pin & i_code_store_strobe & ~fuse_r & ctrl_en_r; // see [R20]
  assign strobe_rise = i_prog_strobe & ~strobe_r;
  assign strobe_fall = ~i_prog_strobe & strobe_r;
  assign mode_rd = (i_par_req.mode == `FPL_MODE_READ); // see [R12] see [R23]
  assign mode_sig = (i_par_req.mode == `FPL_MODE_SIG); // see [R21]
  assign erasing = (st_r == ST_SERASE) || (st_r == ST_PERASE) || erase_busy;
  assign wr_done = ((st_r == ST_PWRITE) || (st_r == ST_SWRITE) || (st_r == ST_LOCKW))
                 && (tmr_r == `FPL_TMR_W'(WRITE_CYC - 1)); // see [R11]
  assign erase_start = ((st_r == ST_IDLE) && par_on && strobe_fall
                     && i_par_req.mode == `FPL_MODE_ERASE) || ser_erase;

  // Serial instruction decode on the third byte
  assign ser_go = rx_valid && (ser_idx_r == 2'h2) && ser_en_r && ser_on
                && (st_r == ST_IDLE);
  assign ser_wr = ser_go && (b1_r[1:0] == `FPL_SER_WR) && !lock_r[0]; // see [R5]
  assign ser_lock = ser_go && (b1_r == `FPL_SER_PREFIX) && (b2_r[2:0] == `FPL_SER_LOCK);
  assign ser_erase = ser_go && (b1_r == `FPL_SER_PREFIX)
                   && (b2_r[2:0] == `FPL_SER_ERASE); // see [R18]

  fpl_ser_shift u_shift (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_active(i_dev_reset_pin & i_code_store_strobe),
    .i_sck(i_sck),
    .i_mosi(i_mosi),
    .i_tx_load(rd_pend_r[1]),
    .i_tx_byte(ser_tx),
    .o_miso(o_miso),
    .o_rx_byte(rx_byte),
    .o_rx_valid(rx_valid)
  );

  fpl_flash_array u_array (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_rd_addr(rd_pend_r[0] ? ser_addr_r : i_par_req.addr), // see [R1]
    .o_rd_data(rd_data),
    .i_wr_en(wr_done && (st_r != ST_LOCKW)),
    .i_wr_and(st_r == ST_PWRITE),
    .i_wr_addr(last_addr_r),
    .i_wr_data(last_data_r),
    .i_erase_start(erase_start),
    .o_erase_busy(erase_busy)
  );

  // Sequencer: one operation at a time; refused requests leave it idle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (par_on && strobe_rise && i_par_req.mode == `FPL_MODE_WRITE
              && !lock_r[0]) begin
            st_r <= ST_PWRITE; // see [R11] see [R25]
          end else if (par_on && strobe_rise && i_par_req.mode == `FPL_MODE_LOCK) begin
            st_r <= ST_LOCKW;
          end else if (erase_start && !ser_erase) begin
            st_r <= ST_PERASE; // see [R17]
          end else if (ser_wr) begin
            st_r <= ST_SWRITE; // see [R3]
          end else if (ser_lock) begin
            st_r <= ST_LOCKW;
          end else if (ser_erase) begin
            st_r <= ST_SERASE;
          end
        end
        ST_PWRITE, ST_SWRITE, ST_LOCKW: begin
          if (wr_done) begin
            st_r <= ST_IDLE; // see [R14]
          end
        end
        ST_SERASE: begin
          if (tmr_r == `FPL_TMR_W'(SERASE_CYC - 1) && !erase_busy) begin
            st_r <= ST_IDLE; // see [R18]
          end
        end
        ST_PERASE: begin
          // Strobe must stay low for the erase time; the programmer owns it
          if (i_prog_strobe && !erase_busy) begin
            st_r <= ST_IDLE; // see [R17]
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Operation timer, idle at zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tmr_r <= '0;
    end else if (st_r == ST_IDLE || wr_done) begin
      tmr_r <= '0;
    end else if (tmr_r != '1) begin
      tmr_r <= tmr_r + `FPL_TMR_W'(1);
    end
  end

  // Strobe edge detect and the byte being written
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      strobe_r <= 1'b1;
      last_addr_r <= '0;
      last_data_r <= `FPL_ERASED;
      lock_pend_r <= 3'h0;
      fuse_pend_r <= 1'b0;
    end else begin
      strobe_r <= i_prog_strobe;
      if (st_r == ST_IDLE && par_on && strobe_rise) begin
        if (i_par_req.mode == `FPL_MODE_WRITE && !lock_r[0]) begin
          last_addr_r <= i_par_req.addr; // see [R10]
          last_data_r <= i_par_req.data;
        end
        // Data bits at zero program the matching lock bits and the fuse
        lock_pend_r <= {<<{~i_par_req.data[7:5]}};
        fuse_pend_r <= ~i_par_req.data[4];
      end else if (ser_wr) begin
        last_addr_r <= {b1_r[7:2], b2_r};
        last_data_r <= rx_byte;
      end else if (ser_lock) begin
        lock_pend_r <= {<<{~b2_r[7:5]}};
        fuse_pend_r <= 1'b0; // see [R20]
      end
    end
  end

  // Lock bits and fuse: set by lock writes, cleared only by chip erase
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lock_r <= 3'h0;
      fuse_r <= 1'b0; // see [R20]
    end else if (wr_done && st_r == ST_LOCKW) begin
      lock_r <= lock_r | lock_pend_r;
      fuse_r <= fuse_r | fuse_pend_r;
    end else if (st_r == ST_SERASE || st_r == ST_PERASE) begin
      lock_r <= 3'h0; // see [R9]
      if (st_r == ST_PERASE) begin
        fuse_r <= 1'b0;
      end
    end
  end

  // Access pin level caught while the device reset pin is held
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ea_latch_r <= 1'b0;
    end else if (i_dev_reset_pin) begin
      ea_latch_r <= i_external_fetch_select; // see [R8]
    end
  end
  assign o_ea_latched = ea_latch_r;
  assign o_external_fetch_used = lock_r[0] ? ea_latch_r : i_external_fetch_select; // see [R5]
  assign o_code_table_read_block = lock_r[0]; // see [R5]
  assign o_ext_exec_block = lock_r[2]; // see [R7]
  // Busy only for parallel byte writes; refused requests never get here
  assign o_ready_busy_indicator = (st_r != ST_PWRITE); // see [R15]

  // Serial framing: three bytes an instruction, reset by the reset pin
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ser_idx_r <= 2'h0;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      ser_en_r <= 1'b0;
      rd_pend_r <= 2'h0;
      ser_addr_r <= '0;
    end else begin
      rd_pend_r <= {rd_pend_r[0], 1'b0};
      if (!i_dev_reset_pin || !i_code_store_strobe) begin
        ser_idx_r <= 2'h0;
        ser_en_r <= 1'b0;
      end else if (rx_valid) begin
        ser_idx_r <= (ser_idx_r == 2'h2) ? 2'h0 : ser_idx_r + 2'h1; // see [R24]
        if (ser_idx_r == 2'h0) begin
          b1_r <= rx_byte;
        end else if (ser_idx_r == 2'h1) begin
          b2_r <= rx_byte;
          if (b1_r[1:0] == `FPL_SER_RD) begin
            ser_addr_r <= {b1_r[7:2], rx_byte};
            rd_pend_r[0] <= 1'b1;
          end
        end else if (b1_r == `FPL_SER_PREFIX && b2_r == `FPL_SER_ENABLE) begin
          ser_en_r <= !fuse_r; // see [R24]
        end
      end
    end
  end

  // Serial read answer, loaded before the third byte starts shifting
  always_comb begin
    if (!ser_en_r || !ser_on || lock_r[1]) begin
      ser_tx = `FPL_ERASED; // see [R6]
    end else if (erasing) begin
      ser_tx = `FPL_ERASE_READ; // see [R19]
    end else if (st_r == ST_SWRITE && ser_addr_r == last_addr_r) begin
      ser_tx = {~last_data_r[7], last_data_r[6:0]}; // see [R13]
    end else begin
      ser_tx = rd_data;
    end
  end

  // Parallel data port, registered; lock two withholds code readback
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pdata <= 8'h00;
      o_pdata_oe <= 1'b0;
    end else begin
      o_pdata_oe <= par_on && ((mode_rd && !lock_r[1]) || mode_sig); // see [R16]
      if (mode_sig) begin
        case (i_par_req.addr)
          `FPL_SIG0_ADDR: o_pdata <= ID_MAKER; // see [R21]
          `FPL_SIG1_ADDR: o_pdata <= ID_PART;
          `FPL_LOCK_ADDR: o_pdata <= {4'h0, fuse_r, lock_r}; // see [R16]
          default: o_pdata <= 8'h00;
        endcase
      end else if (st_r == ST_PWRITE && i_par_req.addr == last_addr_r) begin
        o_pdata <= {~last_data_r[7], last_data_r[6:0]}; // see [R13]
      end else begin
        o_pdata <= rd_data; // see [R12] see [R2]
      end
    end
  end

  // APB slave: zero wait, read data captured in the setup cycle
  assign apb_acc = i_psel & i_penable;
  assign mapped = (i_paddr == `FPL_REG_STATUS) || (i_paddr == `FPL_REG_CTRL)
                || (i_paddr == `FPL_REG_LAST);
  assign o_pready = 1'b1;
  assign o_pslverr = apb_acc & ~mapped;
  always_comb begin
    case (i_paddr)
      `FPL_REG_STATUS: rd_mux = {24'h0, erasing, st_r != ST_IDLE, ser_en_r,
                                 ea_latch_r, fuse_r, lock_r};
      `FPL_REG_CTRL: rd_mux = {31'h0, ctrl_en_r};
      `FPL_REG_LAST: rd_mux = {10'h0, last_addr_r, last_data_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      ctrl_en_r <= `FPL_CTRL_RESET;
    end else begin
      if (i_psel && !i_penable && !i_pwrite) begin
        o_prdata <= rd_mux;
      end
      if (apb_acc && i_pwrite && i_paddr == `FPL_REG_CTRL) begin
        ctrl_en_r <= i_pwdata[0];
      end
    end
  end

  a_busy_low: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R15]
    (st_r == ST_IDLE && par_on && strobe_rise && i_par_req.mode == `FPL_MODE_WRITE
     && !lock_r[0]) |=> !o_ready_busy_indicator)
    else $error("ready/busy not low after write strobe");
  a_lock_refuse: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R25]
    (st_r == ST_IDLE && lock_r[0] && !ser_lock && !erase_start
     && !(par_on && strobe_rise)) |=> st_r == ST_IDLE)
    else $error("write accepted under lock one");
  a_poll_invert: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R13]
    (st_r == ST_PWRITE && !wr_done && !mode_sig && i_par_req.addr == last_addr_r)
    |=> o_pdata[7] != last_data_r[7])
    else $error("polling bit not inverted");
  a_verify_lock: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R6]
    (lock_r[1] && !mode_sig) |=> !o_pdata_oe)
    else $error("code readback under lock two");
  a_erase_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R9]
    (st_r == ST_SERASE) ##1 (st_r == ST_IDLE) |-> lock_r == 3'h0)
    else $error("lock bits survive erase");
  a_erase_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R19]
    (rd_pend_r[1] && st_r == ST_SERASE && ser_en_r && ser_on && !lock_r[1])
    |-> ser_tx == 8'h00)
    else $error("serial read during erase not zero");
  a_fuse_block: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R20]
    $rose(fuse_r) |-> !ser_on)
    else $error("serial path open with fuse set");
  a_sig_maker: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R21]
    (par_on && mode_sig && i_par_req.addr == `FPL_SIG0_ADDR)
    |=> o_pdata_oe && o_pdata == ID_MAKER)
    else $error("maker code not returned");
  a_ext_block: assert property (@(posedge i_clk_sys) disable iff (i_rst) // see [R7]
    (wr_done && st_r == ST_LOCKW && lock_pend_r[2]) |=> o_ext_exec_block)
    else $error("lock three did not block external execution");
endmodule : fpl_top

// *** fpl_prog_model.sv ***
// Programmer model: drives the parallel and serial programming pins.
// Assumes one i_clk_sys domain; every pin changes just after a rising edge.
`timescale 1ns/1ps
module fpl_prog_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_pdata,
  input wire logic i_pdata_oe,
  input wire logic i_miso,
  output logic o_dev_reset_pin,
  output logic o_code_store_strobe,
  output logic o_external_fetch_select,
  output logic o_external_fetch_program_voltage,
  output logic o_prog_strobe,
  output fpl_pkg::fpl_par_req_t o_par_req,
  output logic o_sck,
  output logic o_mosi
);
  import fpl_pkg::*;
  // Pull-ups: an undriven data port reads ones
  wire [7:0] bus = i_pdata_oe ? i_pdata : 8'hFF;
  // Programming entry levels from time zero
  initial begin
    o_dev_reset_pin = 1'b1;
    o_code_store_strobe = 1'b0;
    o_external_fetch_select = 1'b1;
    o_external_fetch_program_voltage = 1'b1;
    o_prog_strobe = 1'b1;
    o_par_req = '{4'h3, 14'h0000, 8'h00};
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end
  // Mode, address and data stand with the strobe; one pulse per operation
  task automatic par_op(input logic [3:0] m, input logic [13:0] a, input logic [7:0] d,
    input int low);
    @(posedge i_clk_sys);
    o_par_req <= '{m, a, d};
    o_prog_strobe <= 1'b0;
    repeat (low) @(posedge i_clk_sys);
    o_prog_strobe <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask : par_op
  // Verify read: output lags the pins by two cycles, so wait four
  task automatic par_rd(input logic [3:0] m, input logic [13:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_par_req <= '{m, a, 8'h00};
    repeat (4) @(posedge i_clk_sys);
    d = bus;
  endtask : par_rd
  // Three-byte frame, MSB first; clock stands low between frames
  task automatic ser(input logic [23:0] w, output logic [7:0] r);
    o_code_store_strobe <= 1'b1;
    for (int i = 23; i >= 0; i--) begin
      @(posedge i_clk_sys);
      o_mosi <= w[i];
      repeat (8) @(posedge i_clk_sys);
      o_sck <= 1'b1;
      if (i < 8) r[i] = i_miso;
      repeat (8) @(posedge i_clk_sys);
      o_sck <= 1'b0;
    end
    o_mosi <= ~w[0];
    repeat (8) @(posedge i_clk_sys);
  endtask : ser
endmodule : fpl_prog_model

// *** fpl_top_test.sv ***
// Self-checking bench for the flash program and lock controller.
// Assumes fpl_prog_model drives the pins; APB reaches status and control.
`timescale 1ns/1ps
module fpl_top_test;
  import fpl_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic [7:0] o_pdata, d;
  logic o_pready, o_pslverr, o_pdata_oe, o_ready_busy_indicator, o_miso, o_ext_exec_block;
  logic o_code_table_read_block, i_dev_reset_pin, i_code_store_strobe, i_prog_strobe;
  logic i_external_fetch_select, i_external_fetch_program_voltage, i_sck, i_mosi;
  fpl_par_req_t i_par_req;
  int err_count = 0;
  int checks_done = 0;
  // Short write and erase times
  fpl_top #(.WRITE_CYC(20), .SERASE_CYC(13000)) DUT (
    .i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_dev_reset_pin, .i_code_store_strobe,
    .i_external_fetch_select, .i_external_fetch_program_voltage, .i_prog_strobe,
    .i_par_req, .o_pdata, .o_pdata_oe, .o_ready_busy_indicator, .i_sck, .i_mosi,
    .o_miso, .o_code_table_read_block, .o_ext_exec_block, .o_ea_latched(),
    .o_external_fetch_used());
  fpl_prog_model PGM (.i_clk_sys, .i_pdata(o_pdata), .i_pdata_oe(o_pdata_oe),
    .i_miso(o_miso), .o_dev_reset_pin(i_dev_reset_pin), .o_code_store_strobe(i_code_store_strobe),
    .o_external_fetch_select(i_external_fetch_select), .o_prog_strobe(i_prog_strobe),
    .o_external_fetch_program_voltage(i_external_fetch_program_voltage),
    .o_par_req(i_par_req), .o_sck(i_sck), .o_mosi(i_mosi));
  // 125 MHz clock
  always #4 i_clk_sys = ~i_clk_sys;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  // APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] r, output logic e);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do @(posedge i_clk_sys); while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic ard(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("apb data", r, x);
    chk("apb error", {31'h0, e}, {31'h0, xe});
  endtask : ard
  task automatic awr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, wd, r, e);
  endtask : awr
  task automatic prd(input logic [3:0] m, input logic [13:0] a, input logic [7:0] x);
    PGM.par_rd(m, a, d);
    chk("pdata", {24'h0, d}, {24'h0, x});
  endtask : prd
  // Bounded wait for ready
  task automatic wait_rdy;
    for (int k = 0; k < 100; k++) begin
      if (o_ready_busy_indicator === 1'b1) break;
      @(posedge i_clk_sys);
    end
  endtask : wait_rdy
  task automatic conclude;
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // Watchdog, about twice the sequence
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    err_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    ard(12'h000, 32'h10, 1'b0);
    ard(12'h004, 32'h1, 1'b0);
    awr(12'h004, 32'h0);
    ard(12'h004, 32'h0, 1'b0);
    awr(12'h004, 32'h1);
    ard(12'h00C, 32'h0, 1'b1);
    prd(`FPL_MODE_READ, 14'h0000, 8'hFF);
    prd(`FPL_MODE_READ, 14'h2FFF, 8'hFF);
    PGM.par_op(`FPL_MODE_WRITE, 14'h0010, 8'h5A, 2);
    chk("busy", {31'h0, o_ready_busy_indicator}, 32'h0);
    prd(`FPL_MODE_READ, 14'h0010, 8'hDA);
    wait_rdy();
    prd(`FPL_MODE_READ, 14'h0010, 8'h5A);
    ard(12'h008, 32'h105A, 1'b0);
    PGM.par_op(`FPL_MODE_WRITE, 14'h0010, 8'h0F, 2);
    wait_rdy();
    prd(`FPL_MODE_READ, 14'h0010, 8'h0A);
    prd(`FPL_MODE_SIG, 14'h0030, 8'h5A);
    prd(`FPL_MODE_SIG, 14'h0031, 8'hC3);
    PGM.par_op(`FPL_MODE_LOCK, 14'h0000, 8'h7F, 2);
    repeat (40) @(posedge i_clk_sys);
    chk("table block", {31'h0, o_code_table_read_block}, 32'h1);
    PGM.par_op(`FPL_MODE_WRITE, 14'h0020, 8'h00, 2);
    chk("refused busy", {31'h0, o_ready_busy_indicator}, 32'h1);
    repeat (40) @(posedge i_clk_sys);
    prd(`FPL_MODE_READ, 14'h0020, 8'hFF);
    PGM.par_op(`FPL_MODE_LOCK, 14'h0000, 8'h1F, 2);
    repeat (40) @(posedge i_clk_sys);
    prd(`FPL_MODE_READ, 14'h0010, 8'hFF);
    chk("exec block", {31'h0, o_ext_exec_block}, 32'h1);
    PGM.par_op(`FPL_MODE_ERASE, 14'h0000, 8'h00, 12400);
    repeat (20) @(posedge i_clk_sys);
    chk("lock cleared", {31'h0, o_code_table_read_block}, 32'h0);
    prd(`FPL_MODE_READ, 14'h0010, 8'hFF);
    PGM.ser(24'hAC5300, d);
    PGM.ser(24'h060033, d);
    repeat (40) @(posedge i_clk_sys);
    PGM.ser(24'h06003C, d);
    repeat (40) @(posedge i_clk_sys);
    PGM.ser(24'h050000, d);
    chk("serial read", {24'h0, d}, 32'h3C);
    PGM.ser(24'hAC0400, d);
    PGM.ser(24'h050000, d);
    chk("erase read", {24'h0, d}, 32'h00);
    repeat (13000) @(posedge i_clk_sys);
    PGM.ser(24'h050000, d);
    chk("erased", {24'h0, d}, 32'hFF);
    conclude();
  end
endmodule : fpl_top_test
